// ### core/dsc_cic.sv
module dsc_cic import dsc_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Decimator stream.
  dsc_dec_if.cic   dec
);

  logic signed [CIC_W-1:0] integ [CIC_ORDER];
  logic signed [CIC_W-1:0] dly   [CIC_ORDER];
  logic signed [CIC_W-1:0] comb  [CIC_ORDER+1];

  // Comb chain at the decimated rate; wraparound arithmetic is exact.
  always_comb begin
    comb[0] = integ[CIC_ORDER-1];
    for (int k = 0; k < CIC_ORDER; k++) begin
      comb[k+1] = comb[k] - dly[k];
    end
  end

  // Integrators take the bitstream as plus or minus one per bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        integ[k] <= '0;
      end
    end else if (dec.clr) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        integ[k] <= '0;
      end
    end else if (dec.step) begin
      integ[0] <= integ[0] + (dec.bit_in ? CIC_W'(1) : -CIC_W'(1));
      for (int k = 1; k < CIC_ORDER; k++) begin
        integ[k] <= integ[k] + integ[k-1];
      end
    end
  end

  // Comb delays and the output word, loaded at each decimation point.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        dly[k] <= '0;
      end
      dec.raw     <= '0;
      dec.raw_vld <= 1'b0;
    end else begin
      // A full stop on the emitting dump drops the word, so no stale
      // result can follow the stop.
      dec.raw_vld <= dec.dump && dec.take && !dec.clr;
      if (dec.clr) begin
        for (int k = 0; k < CIC_ORDER; k++) begin
          dly[k] <= '0;
        end
      end else if (dec.dump) begin
        for (int k = 0; k < CIC_ORDER; k++) begin
          dly[k] <= comb[k];
        end
        dec.raw <= comb[CIC_ORDER];
      end
    end
  end

endmodule : dsc_cic

// ### core/dsc_dec_if.sv
interface dsc_dec_if import dsc_pkg::*; ();
  logic                    clr;
  logic                    step;
  logic                    bit_in;
  logic                    dump;
  logic                    take;
  logic                    raw_vld;
  logic signed [CIC_W-1:0] raw;
  logic [3:0]              dsh;
  logic [4:0]              res;
  logic                    gain_en;
  logic                    off_en;
  logic                    filt_en;
  logic [15:0]             gain;
  logic signed [15:0]      offset;
  logic                    out_vld;
  logic signed [31:0]      out;

  modport ctl (output clr, step, bit_in, dump, take, dsh, res,
               gain_en, off_en, filt_en, gain, offset,
               input out_vld, out);
  modport cic (input clr, step, bit_in, dump, take,
               output raw_vld, raw);
  modport post (input clr, raw_vld, raw, dsh, res, gain_en, off_en,
                filt_en, gain, offset,
                output out_vld, out);
endinterface : dsc_dec_if

// ### core/dsc_pkg.sv
package dsc_pkg;

  // Register port geometry and register indices.
  localparam int         ADDR_W     = 4;
  localparam int         DATA_W     = 32;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SEL    = 4'h1;
  localparam logic [3:0] REG_CFG0   = 4'h2;
  localparam logic [3:0] REG_GAIN   = 4'h6;
  localparam logic [3:0] REG_OFFSET = 4'h7;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;

  // Command bits of the control register, each a write-one pulse.
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_FULL  = 2;

  // Status register fields.
  localparam int STAT_RUN   = 0;
  localparam int STAT_PRIME = 1;
  localparam int STAT_SEL   = 3;

  // Number of stored configurations and the layout of one of them.
  localparam int N_CFG     = 4;
  localparam int CFG_W     = 15;
  localparam int CFG_MODE  = 0;
  localparam int CFG_RES   = 2;
  localparam int CFG_DSH   = 7;
  localparam int CFG_TRIG  = 11;
  localparam int CFG_GAIN  = 12;
  localparam int CFG_OFF   = 13;
  localparam int CFG_FILT  = 14;
  // Single sample, 16 bits, decimation by 256, no post-processing.
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0440;
  localparam logic [1:0]       SEL_RESET = 2'h0;

  // Conversion modes.
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_MULTI  = 2'h1,
    MODE_CONT   = 2'h2,
    MODE_TURBO  = 2'h3
  } dsc_mode_e;

  // Resolution limits and the turbo threshold.
  localparam logic [4:0] RES_MIN   = 5'h08;
  localparam logic [4:0] RES_MAX   = 5'h14;
  localparam logic [4:0] TURBO_RES = 5'h10;

  // Decimation as a power of two; turbo divides the ratio by four.
  localparam logic [3:0] DSH_MIN  = 4'h2;
  localparam logic [3:0] DSH_MAX  = 4'hA;
  localparam logic [3:0] TURBO_SH = 4'h2;
  localparam int         DEC_W    = 10;
  localparam int         CIC_ORDER = 4;
  localparam int         CIC_W    = CIC_ORDER * 10 + 2;
  localparam logic [1:0] PRIME_LAST = 2'h2;

  // Post-processing constants, gain is unsigned with 12 fraction bits.
  localparam logic [15:0] GAIN_RESET   = 16'h1000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam int          GAIN_FRAC    = 12;

  // Modulator bit period and the divider count derived from the clock.
  localparam int CLK_MHZ       = 250;
  localparam int MOD_PERIOD_NS = 16;
  localparam int MOD_DIV       = (MOD_PERIOD_NS * CLK_MHZ + 999) / 1000;

  // Clamps a requested resolution into the supported range.
  function automatic logic [4:0] dsc_res(input logic [4:0] r);
    if (r < RES_MIN) begin
      return RES_MIN;
    end
    if (r > RES_MAX) begin
      return RES_MAX;
    end
    return r;
  endfunction : dsc_res

  // Effective decimation shift, two less for high-res turbo, so the ratio is a quarter.
  function automatic logic [3:0] dsc_dsh(input logic [3:0] d,
                                         input logic [4:0] r,
                                         input dsc_mode_e  m);
    logic [3:0] v;
    v = (d < DSH_MIN) ? DSH_MIN : ((d > DSH_MAX) ? DSH_MAX : d);
    if (m == MODE_TURBO && r > TURBO_RES && v >= DSH_MIN + TURBO_SH) begin
      v = v - TURBO_SH;
    end
    return v;
  endfunction : dsc_dsh

endpackage : dsc_pkg

// ### core/dsc_post.sv
module dsc_post import dsc_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Decimator stream.
  dsc_dec_if.post  dec
);

  logic signed [31:0] y;
  logic               y_ok;
  logic signed [31:0] v_scl;
  logic signed [31:0] v_gain;
  logic signed [31:0] v_off;
  logic signed [31:0] v_filt;
  logic signed [48:0] prod;
  logic signed [32:0] fsum;

  // Brings the CIC full scale down to the chosen resolution.
  function automatic logic signed [31:0] scale(
      input logic signed [CIC_W-1:0] r, input logic [3:0] d,
      input logic [4:0] rs);
    int                      sh;
    logic signed [CIC_W-1:0] t;
    sh = CIC_ORDER * int'(d) + 1 - int'(rs);
    t = (sh >= 0) ? (r >>> sh) : (r <<< (-sh));
    return t[31:0];
  endfunction : scale

  // Clips to the signed range of the resolution rather than wrapping.
  function automatic logic signed [31:0] clip(
      input logic signed [31:0] v, input logic [4:0] rs);
    logic signed [31:0] hi;
    hi = (32'sh1 <<< (int'(rs) - 1)) - 32'sh1;
    if (v > hi) begin
      return hi;
    end
    if (v < -hi - 32'sh1) begin
      return -hi - 32'sh1;
    end
    return v;
  endfunction : clip

  // Optional gain, offset and averaging, each selected separately.
  always_comb begin
    v_scl  = scale(dec.raw, dec.dsh, dec.res);
    prod   = v_scl * $signed({1'b0, dec.gain});
    v_gain = dec.gain_en ? prod[GAIN_FRAC+31:GAIN_FRAC] : v_scl;
    v_off  = dec.off_en ? v_gain + 32'(dec.offset) : v_gain;
    fsum   = {y[31], y} + {v_off[31], v_off};
    v_filt = (dec.filt_en && y_ok) ? fsum[32:1] : v_off;
  end

  // A flush empties the averager so the next sample starts fresh.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      y           <= '0;
      y_ok        <= 1'b0;
      dec.out     <= '0;
      dec.out_vld <= 1'b0;
    end else begin
      dec.out_vld <= dec.raw_vld;
      if (dec.raw_vld) begin
        dec.out <= clip(v_filt, dec.res);
        y       <= v_filt;
        y_ok    <= !dec.clr;
      end else if (dec.clr) begin
        y_ok <= 1'b0;
      end
    end
  end

endmodule : dsc_post

// ### core/dsc_top.sv
// How it works
// - With triggering enabled, each trigger rising edge starts like software.
// - The trigger input only acts when the trigger option is built in.
// - Single mode does one conversion per start, then halts.
// - Other modes keep converting until stop or full stop.
// - Each result raises done for exactly one clock.
// - Mode codes: 0 single, 1 multi, 2 continuous, 3 turbo.
// - Multi mode resets modulator and flushes filters between samples.
// - Continuous mode withholds its first result for three periods.
// - After priming, continuous mode yields a result every period.
// - Turbo equals multi mode for 8 to 16 bit resolutions.
// - Turbo converts four times faster for 17 to 20 bits when the decimation shift is 4 or more.
// - Result resolution selectable from 8 to 20 bits.
// - Decimation uses a four-stage CIC on the raw bitstream.
// - Gain, offset and filter follow the CIC, each selectable.
// - Results are signed positive-minus-negative differences.
// - Four stored configurations, any one selectable while running.
// - The first stored configuration is active after reset.
//
// The strobed register port and the placing of the registers are this design's own decisions.
module dsc_top import dsc_pkg::*; #(
  parameter bit HAS_TRIG = 1'b1,
  parameter int DIV      = MOD_DIV
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Pins.
  input  wire logic              conv_trig,
  input  wire logic              mod_bit,
  // Conversion outputs.
  output logic                   done,
  output logic      [31:0]       result,
  output logic                   mod_rst,
  output logic                   running
);

  // The divider counter is sixteen bits, so larger ratios cannot be served.
  if (DIV < 1 || DIV > 65535) begin : g_div_check
    $error("dsc_top: DIV out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FLUSH = 2'h1,
    ST_RUN   = 2'h3
  } dsc_state_e;

  dsc_dec_if dec ();

  logic [CFG_W-1:0] cfg [N_CFG];
  logic [1:0]       sel;
  logic [15:0]      gain;
  logic [15:0]      offset;
  logic [2:0]       tsync;
  logic [2:0]       msync;
  logic             trig_lvl;
  logic             trig_prev;
  logic             mod_lvl;
  logic [15:0]      div_cnt;
  logic             mod_en;
  dsc_state_e       state;
  dsc_state_e       next_state;
  logic [DEC_W-1:0] dec_cnt;
  logic [1:0]       prime_cnt;
  logic [CFG_W-1:0] act;
  dsc_mode_e        mode;
  logic [4:0]       res;
  logic [3:0]       dsh;
  logic [DEC_W-1:0] dec_last;
  logic             ctrl_wr;
  logic             sw_start;
  logic             stop_req;
  logic             full_req;
  logic             hw_start;
  logic             start_req;
  logic             dump;
  logic             emit;

  // The active configuration is read live, so switching takes effect
  // at once; a switch mid-sample can mix settings in that sample.
  always_comb begin
    act      = cfg[sel];
    mode     = dsc_mode_e'(act[CFG_MODE +: 2]);
    res      = dsc_res(act[CFG_RES +: 5]);
    dsh      = dsc_dsh(act[CFG_DSH +: 4], res, mode);
    dec_last = DEC_W'((11'h001 << dsh) - 11'h001);
  end

  // Command pulses written to the control register.
  always_comb begin
    ctrl_wr   = wr && (addr == REG_CTRL);
    sw_start  = ctrl_wr && wdata[CTRL_START];
    full_req  = ctrl_wr && wdata[CTRL_FULL];
    stop_req  = ctrl_wr && (wdata[CTRL_STOP] || wdata[CTRL_FULL]);
    hw_start  = HAS_TRIG && act[CFG_TRIG] && trig_lvl && !trig_prev;
    start_req = sw_start || hw_start;
  end

  // Configuration registers; the first one is active after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < N_CFG; k++) begin
        cfg[k] <= CFG_RESET;
      end
      sel    <= SEL_RESET;
      gain   <= GAIN_RESET;
      offset <= OFFSET_RESET;
    end else if (wr) begin
      for (int k = 0; k < N_CFG; k++) begin
        if (addr == REG_CFG0 + 4'(k)) begin
          cfg[k] <= wdata[CFG_W-1:0];
        end
      end
      if (addr == REG_SEL) begin
        sel <= wdata[1:0];
      end
      if (addr == REG_GAIN) begin
        gain <= wdata[15:0];
      end
      if (addr == REG_OFFSET) begin
        offset <= wdata[15:0];
      end
    end
  end

  // Pin synchronisers: a new level counts once the last two stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsync     <= 3'h0;
      msync     <= 3'h0;
      trig_lvl  <= 1'b0;
      trig_prev <= 1'b0;
      mod_lvl   <= 1'b0;
    end else begin
      tsync     <= {tsync[1:0], conv_trig};
      msync     <= {msync[1:0], mod_bit};
      trig_prev <= trig_lvl;
      if (tsync[1] == tsync[2]) begin
        trig_lvl <= tsync[2];
      end
      if (msync[1] == msync[2]) begin
        mod_lvl <= msync[2];
      end
    end
  end

  // Divider giving the modulator bit rate as a one-cycle enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      mod_en  <= 1'b0;
    end else begin
      mod_en  <= (div_cnt == 16'(DIV - 1));
      div_cnt <= (div_cnt == 16'(DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // A dump closes one conversion period; only primed dumps give results.
  always_comb begin
    dump = (state == ST_RUN) && mod_en && (dec_cnt == dec_last);
    emit = dump && (prime_cnt == PRIME_LAST);
  end

  // Sequencer. Starts are taken only when idle, so a retrigger during a
  // conversion is dropped rather than queued.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_req && !stop_req) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (stop_req) begin
          next_state = ST_IDLE;
        end else if (mod_en) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          next_state = ST_IDLE;
        end else if (emit && mode == MODE_SINGLE) begin
          next_state = ST_IDLE;
        end else if (emit && mode != MODE_CONT) begin
          next_state = ST_FLUSH;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Decimation and priming counters, cleared on every flush.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt   <= '0;
      prime_cnt <= 2'h0;
    end else if (state != ST_RUN) begin
      dec_cnt   <= '0;
      prime_cnt <= 2'h0;
    end else if (mod_en) begin
      dec_cnt <= dump ? '0 : dec_cnt + DEC_W'(1);
      if (dump && prime_cnt != PRIME_LAST) begin
        prime_cnt <= prime_cnt + 2'h1;
      end
    end
  end

  // Decimator controls; a full stop also empties the filters.
  always_comb begin
    dec.clr     = (state == ST_FLUSH) || full_req;
    dec.step    = (state == ST_RUN) && mod_en;
    dec.bit_in  = mod_lvl;
    dec.dump    = dump;
    dec.take    = emit;
    dec.dsh     = dsh;
    dec.res     = res;
    dec.gain_en = act[CFG_GAIN];
    dec.off_en  = act[CFG_OFF];
    dec.filt_en = act[CFG_FILT];
    dec.gain    = gain;
    dec.offset  = offset;
  end

  dsc_cic u_cic (
    .clk   (clk),
    .rst_n (rst_n),
    .dec   (dec.cic)
  );

  dsc_post u_post (
    .clk   (clk),
    .rst_n (rst_n),
    .dec   (dec.post)
  );

  // Outputs straight from flops; done lasts exactly one clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done    <= 1'b0;
      result  <= 32'h0000_0000;
      mod_rst <= 1'b0;
      running <= 1'b0;
    end else begin
      done    <= dec.out_vld;
      mod_rst <= (next_state == ST_FLUSH);
      running <= (next_state != ST_IDLE);
      if (dec.out_vld) begin
        result <= dec.out;
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= 32'h0000_0000;
      for (int k = 0; k < N_CFG; k++) begin
        if (addr == REG_CFG0 + 4'(k)) begin
          rdata <= 32'(cfg[k]);
        end
      end
      unique case (addr)
        REG_SEL:    rdata <= 32'(sel);
        REG_GAIN:   rdata <= 32'(gain);
        REG_OFFSET: rdata <= 32'(offset);
        REG_RESULT: rdata <= result;
        REG_STATUS: begin
          rdata             <= 32'h0000_0000;
          rdata[STAT_RUN]   <= running;
          rdata[STAT_PRIME +: 2] <= prime_cnt;
          rdata[STAT_SEL +: 2]   <= sel;
        end
        default: begin
        end
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule : dsc_top

// ### test/dsc_partner.sv
module dsc_partner #(
  parameter int HOLD = 4
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench requests.
  input  wire logic fire,
  input  wire logic level,
  // Converter pins.
  output logic      conv_trig,
  output logic      mod_bit,
  input  wire logic done,
  output int        req_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_cnt;

  // A trigger is held several clocks so the input filter accepts it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 0;
    end else if (fire) begin
      hold_cnt <= HOLD;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  assign conv_trig = hold_cnt > 0;

  // The bitstream follows the asked level one clock later, whether or not a conversion runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_bit <= 1'b0;
    end else begin
      mod_bit <= level;
    end
  end

  // Every done pulse is serviced as one request event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_cnt <= 0;
    end else if (done) begin
      req_cnt <= req_cnt + 1;
    end
  end
endmodule : dsc_partner

// ### test/dsc_top_assertions.sv
module dsc_top_assertions import dsc_pkg::*; #(
  parameter bit HAS_TRIG = 1'b1,
  parameter int DIV      = MOD_DIV
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // Pins and conversion outputs.
  input wire logic              conv_trig,
  input wire logic              mod_bit,
  input wire logic              done,
  input wire logic [31:0]       result,
  input wire logic              mod_rst,
  input wire logic              running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start_req;
  logic stop_req;
  int   flush_len;

  // Pure command writes; mixed commands are left unjudged.
  assign start_req = wr && addr == REG_CTRL && wdata[2:0] == 3'h1;
  assign stop_req  = wr && addr == REG_CTRL && wdata[2:0] == 3'h2;

  // Counts how long the modulator has been held in reset so far.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_len <= 0;
    end else begin
      flush_len <= mod_rst ? flush_len + 1 : 0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_done_spacing: assert property (done |=> !done [*3])
    else $error("done pulse too long or results too close");
  chk_result_hold: assert property (!done |-> $stable(result))
    else $error("result changed without done");
  chk_start_runs: assert property (start_req && !running |-> ##[1:2] running)
    else $error("idle start did not begin a conversion");
  chk_stop_halts: assert property (stop_req |-> ##[1:2] !running)
    else $error("stop did not return to idle");
  chk_flush_run: assert property (mod_rst |-> running)
    else $error("modulator reset outside a conversion");
  chk_flush_bound: assert property (mod_rst |-> flush_len <= DIV)
    else $error("flush longer than one bit period");
  chk_rdata_quiet: assert property (!rd |=> rdata == '0)
    else $error("read data outside a read answer");
  chk_ctrl_read: assert property (rd && addr == REG_CTRL |=> rdata == '0)
    else $error("command register read nonzero");
  chk_cfg_width: assert property (
      rd && addr >= REG_CFG0 && addr < REG_GAIN
      |=> rdata[DATA_W-1:CFG_W] == '0)
    else $error("configuration reserved bits set");
endmodule : dsc_top_assertions

bind dsc_top dsc_top_assertions #(.HAS_TRIG(HAS_TRIG), .DIV(DIV)) u_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .conv_trig(conv_trig), .mod_bit(mod_bit),
  .done(done), .result(result), .mod_rst(mod_rst), .running(running)
);

// ### test/dsc_top_test.sv
module dsc_top_test import dsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIVT = 1;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [31:0]       wdata = 32'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic              conv_trig;
  logic              mod_bit;
  logic              done;
  logic [31:0]       result;
  logic              mod_rst;
  logic              running;
  logic              fire = 1'b0;
  logic              lvl = 1'b1;
  logic              saw_flush;
  int                req_cnt;
  int                mismatches = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                pm, p16, p20, pm20;

  // Even halves keep the converter clock at half duty.
  always #2 clk = ~clk;

  dsc_top #(.HAS_TRIG(1'b1), .DIV(DIVT)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .conv_trig(conv_trig), .mod_bit(mod_bit),
    .done(done), .result(result), .mod_rst(mod_rst), .running(running)
  );
  dsc_partner u_far (
    .clk(clk), .rst_n(rst_n), .fire(fire), .level(lvl),
    .conv_trig(conv_trig), .mod_bit(mod_bit), .done(done),
    .req_cnt(req_cnt)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk_val(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk_val

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Bounded wait so a missing result cannot hang the run.
  task automatic wait_done(output int t);
    t = 0;
    saw_flush = 1'b0;
    do begin
      @(posedge clk);
      #1;
      t++;
      saw_flush |= mod_rst;
    end while (done !== 1'b1 && t < 400);
    chk_val("done seen", 32'h1, 32'(done));
  endtask : wait_done

  function automatic logic [31:0] cfgw(dsc_mode_e m, logic [4:0] r,
                                       logic [3:0] d, logic g);
    return 32'(m) | 32'(r) << CFG_RES | 32'(d) << CFG_DSH
           | 32'(g) << CFG_TRIG;
  endfunction : cfgw

  task automatic t_regs;
    logic [31:0] v;
    for (int i = 2; i < 6; i++) begin
      rd_reg(4'(i), v);
      chk_val("cfg reset", 32'(CFG_RESET), v);
    end
    rd_reg(REG_GAIN, v);
    chk_val("gain reset", 32'(GAIN_RESET), v);
    rd_reg(4'hF, v);
    chk_val("unmapped", 32'h0, v);
    rd_reg(REG_CTRL, v);
    chk_val("ctrl read", 32'h0, v);
    wr_reg(REG_SEL, 32'h3);
    rd_reg(REG_STATUS, v);
    chk_val("active sel", 32'h3, 32'(v[4:3]));
    wr_reg(REG_CFG0 + 4'h3, 32'hFFFF_0C42);
    rd_reg(REG_CFG0 + 4'h3, v);
    chk_val("cfg store", 32'h0C42, v);
    wr_reg(REG_SEL, 32'h0);
  endtask : t_regs

  task automatic t_single;
    int t;
    int n;
    logic [31:0] v;
    wr_reg(REG_CFG0, cfgw(MODE_SINGLE, 5'h08, 4'h2, 1'b0));
    n = req_cnt;
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wait_done(t);
    chk_val("single done", 32'h1, 32'(done));
    chk_val("plus sign", 32'h0, 32'(result[31]));
    rd_reg(REG_RESULT, v);
    chk_val("result reg", 32'h0000_005F, v);
    repeat (60) @(posedge clk);
    chk_val("single count", 32'(n + 1), 32'(req_cnt));
    lvl <= 1'b0;
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wait_done(t);
    chk_val("minus sign", 32'h1, 32'(result[31]));
    lvl <= 1'b1;
    // Half gain then plus five on the same positive stream.
    wr_reg(REG_GAIN, 32'h0000_0800);
    wr_reg(REG_OFFSET, 32'h0000_0005);
    wr_reg(REG_CFG0, cfgw(MODE_SINGLE, 5'h08, 4'h2, 1'b0) | 32'h3000);
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wait_done(t);
    chk_val("gain offset", 32'h0000_0034, result);
  endtask : t_single

  task automatic t_cont;
    int t;
    int n;
    wr_reg(REG_CFG0, cfgw(MODE_CONT, 5'h10, 4'h2, 1'b0));
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wait_done(t);
    chk_val("prime wait", 32'h1, 32'(t >= 12 * DIVT));
    repeat (2) begin
      wait_done(t);
      chk_val("cont period", 32'(4 * DIVT), 32'(t));
    end
    wr_reg(REG_CTRL, 32'h1 << CTRL_FULL);
    repeat (5) @(posedge clk);
    n = req_cnt;
    repeat (40) @(posedge clk);
    chk_val("halted", 32'(n), 32'(req_cnt));
    chk_val("stopped", 32'h0, 32'(running));
  endtask : t_cont

  task automatic t_period(input dsc_mode_e m, input logic [4:0] r,
                          output int p);
    int t;
    wr_reg(REG_CFG0, cfgw(m, r, 4'h4, 1'b0));
    wr_reg(REG_CTRL, 32'h1 << CTRL_START);
    wait_done(t);
    wait_done(p);
    chk_val("flush seen", 32'h1, 32'(saw_flush));
    wait_done(t);
    chk_val("steady period", 32'(p), 32'(t));
    wr_reg(REG_CTRL, 32'h1 << CTRL_STOP);
    repeat (5) @(posedge clk);
  endtask : t_period

  task automatic t_trig;
    int t;
    int n;
    wr_reg(REG_CFG0, cfgw(MODE_SINGLE, 5'h0C, 4'h2, 1'b1));
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_done(t);
    chk_val("trig start", 32'h1, 32'(done));
    wr_reg(REG_CFG0, cfgw(MODE_SINGLE, 5'h0C, 4'h2, 1'b0));
    n = req_cnt;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (40) @(posedge clk);
    chk_val("trig off", 32'(n), 32'(req_cnt));
  endtask : t_trig

  // Cuts a hung run short well beyond the expected run of under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_single();
    t_cont();
    t_period(MODE_MULTI, 5'h10, pm);
    t_period(MODE_TURBO, 5'h10, p16);
    chk_val("turbo low res", 32'(pm), 32'(p16));
    t_period(MODE_TURBO, 5'h14, p20);
    t_period(MODE_MULTI, 5'h14, pm20);
    chk_val("turbo high res", 32'h1, 32'(2 * p20 < pm20));
    t_trig();
    complete_run();
  end
endmodule : dsc_top_test
